// >>> hw/scrb_bank.sv
/*
  Serial-port configuration register bank of a multichannel converter.
  Assumes an external frame engine presents byte accesses synchronous to
  ref_clk: addr_load starts a stream at addr_in, wr_en/rd_en act on the current
  address and then step it.
*/
// How it works
// - Writing one to the chip reset bit resets all internal state and every register, that bit included.
// - The chip reset bit clears itself, so software never writes zero to release it.
// - Streaming steps the address down when ascend is zero and up when it is one; ascend resets to one.
// - The separate-output flag at bit 4 is read-only and reads one; reads use the dedicated output line.
// - Mode bits 1:0 give normal at 0 and full power down at 3; the register resets to 0x00.
// - Offsets 0xC (low byte) and 0xD (high byte) hold a fixed 16-bit read-only maker code.
// - With the freeze bit set the address stays constant for the stream; the register resets to 0x00.
// - The timing-reference control register resets to 0x80 with enables, fine step and delay fields.
`timescale 1ns/1ps
module scrb_bank
  import scrb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        addr_load,
  input  wire logic [14:0] addr_in,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_en,
  output logic [7:0]       rd_data,
  output logic             sdo_select,
  output logic             chip_reset_busy,
  output logic             power_down,
  output logic [1:0]       op_mode,
  output logic             align_processor_enable,
  output logic             align_receiver_enable,
  output logic             align_fine_window_step,
  output logic [3:0]       align_delay_choice
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  scrb_addr_if ai ();
  scrb_addr_step u_step (.a(ai));

  logic [7:0]      sif_cfg;
  logic [7:0]      chip_operating_mode;
  logic [7:0]      stream_address_control;
  logic [7:0]      timing_reference_control;
  logic [14:0]     addr;
  logic [7:0]      quiet_cnt;
  scrb_rst_state_t rst_state;
  logic [7:0]      rd_q;

  logic [7:0]      next_sif_cfg;
  logic [7:0]      next_chip_operating_mode;
  logic [7:0]      next_stream_address_control;
  logic [7:0]      next_timing_reference_control;
  logic [14:0]     next_addr;
  logic [7:0]      next_quiet_cnt;
  scrb_rst_state_t next_rst_state;
  logic [7:0]      next_rd_q;

  // Read decode, used for the read path only
  function automatic logic [7:0] rd_mux(input logic [14:0] a, input logic [7:0] c0, input logic [7:0] c2,
                                        input logic [7:0] c10, input logic [7:0] c29);
    unique case (a)
      SCRB_OFS_SIF_CFG:    rd_mux = c0;
      SCRB_OFS_OP_MODE:    rd_mux = c2;
      SCRB_OFS_MAKER_LO:   rd_mux = SCRB_MAKER_CODE[7:0];
      SCRB_OFS_MAKER_HI:   rd_mux = SCRB_MAKER_CODE[15:8];
      SCRB_OFS_STREAM_CTL: rd_mux = c10;
      SCRB_OFS_TREF_CTL:   rd_mux = c29;
      default:             rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  assign ai.cur_addr = addr;
  assign ai.ascend   = sif_cfg[SCRB_BIT_ASCEND];
  assign ai.freeze   = stream_address_control[SCRB_BIT_ADDR_FREEZE];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state computation
  always_comb begin
    next_sif_cfg                  = sif_cfg;
    next_chip_operating_mode      = chip_operating_mode;
    next_stream_address_control   = stream_address_control;
    next_timing_reference_control = timing_reference_control;
    next_addr                     = addr;
    next_quiet_cnt                = quiet_cnt;
    next_rst_state                = rst_state;
    next_rd_q                     = rd_q;
    unique case (rst_state)
      SCRB_IDLE: begin
        if (addr_load) begin
          next_addr = addr_in;
        end else if (wr_en || rd_en) begin
          next_addr = ai.next_addr;
        end
        if (rd_en && !addr_load) begin
          next_rd_q = rd_mux(addr, sif_cfg, chip_operating_mode, stream_address_control,
                             timing_reference_control);
        end
        if (wr_en && !addr_load) begin
          unique case (addr)
            SCRB_OFS_SIF_CFG: begin
              if (wr_data[SCRB_BIT_CHIP_RESET]) begin
                // Full reset of everything; the trigger is not stored
                next_sif_cfg                  = SCRB_RST_SIF_CFG;
                next_chip_operating_mode      = SCRB_RST_OP_MODE;
                next_stream_address_control   = SCRB_RST_STREAM_CTL;
                next_timing_reference_control = SCRB_RST_TREF_CTL;
                next_addr                     = 15'h0000;
                next_rd_q                     = 8'h00;
                next_quiet_cnt                = SCRB_QUIET_CYC_W;
                next_rst_state                = SCRB_RESETTING;
              end else begin
                // Flag bit stays one whatever is written
                next_sif_cfg = (wr_data & 8'h6f) | 8'h10;
              end
            end
            SCRB_OFS_OP_MODE:    next_chip_operating_mode      = wr_data;
            SCRB_OFS_STREAM_CTL: next_stream_address_control   = wr_data;
            SCRB_OFS_TREF_CTL:   next_timing_reference_control = wr_data;
            default:             ; // Maker code and unmapped: write dropped, a read in the same cycle kept
          endcase
        end
      end
      SCRB_RESETTING: begin
        // Quiet period; accesses are ignored until it ends
        next_quiet_cnt = 8'(quiet_cnt - 8'h01);
        if (quiet_cnt == 8'h01) begin
          next_rst_state = SCRB_IDLE;
        end
      end
      default: next_rst_state = SCRB_IDLE;
    endcase
  end

  // Register update
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sif_cfg                  <= SCRB_RST_SIF_CFG;
      chip_operating_mode      <= SCRB_RST_OP_MODE;
      stream_address_control   <= SCRB_RST_STREAM_CTL;
      timing_reference_control <= SCRB_RST_TREF_CTL;
      addr                     <= 15'h0000;
      quiet_cnt                <= 8'h00;
      rst_state                <= SCRB_IDLE;
      rd_q                     <= 8'h00;
    end else if (clk_en) begin
      sif_cfg                  <= next_sif_cfg;
      chip_operating_mode      <= next_chip_operating_mode;
      stream_address_control   <= next_stream_address_control;
      timing_reference_control <= next_timing_reference_control;
      addr                     <= next_addr;
      quiet_cnt                <= next_quiet_cnt;
      rst_state                <= next_rst_state;
      rd_q                     <= next_rd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data                <= 8'h00;
      sdo_select             <= 1'b1;
      chip_reset_busy        <= 1'b0;
      power_down             <= 1'b0;
      op_mode                <= SCRB_MODE_NORMAL;
      align_processor_enable <= 1'b0;
      align_receiver_enable  <= 1'b0;
      align_fine_window_step <= 1'b0;
      align_delay_choice     <= 4'h0;
    end else if (clk_en) begin
      rd_data                <= next_rd_q;
      sdo_select             <= 1'b1;
      chip_reset_busy        <= (next_rst_state == SCRB_RESETTING);
      power_down             <= (next_chip_operating_mode[1:0] == SCRB_MODE_PDOWN);
      op_mode                <= next_chip_operating_mode[1:0];
      align_processor_enable <= next_timing_reference_control[SCRB_BIT_ALIGN_PROC];
      align_receiver_enable  <= next_timing_reference_control[SCRB_BIT_ALIGN_RECV];
      align_fine_window_step <= next_timing_reference_control[SCRB_BIT_ALIGN_FINE];
      align_delay_choice     <= next_timing_reference_control[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_reset_write;
    clk_en && rst_state == SCRB_IDLE && wr_en && !addr_load && addr == SCRB_OFS_SIF_CFG
      && wr_data[SCRB_BIT_CHIP_RESET];
  endsequence

  property p_chip_reset;
    @(posedge ref_clk) disable iff (!resetn)
      s_reset_write |=> (sif_cfg == SCRB_RST_SIF_CFG && timing_reference_control == SCRB_RST_TREF_CTL
                         && chip_operating_mode == 8'h00);
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip reset did not restore registers");

  property p_self_clear;
    @(posedge ref_clk) disable iff (!resetn)
      s_reset_write |=> !sif_cfg[SCRB_BIT_CHIP_RESET] ##1 !sif_cfg[SCRB_BIT_CHIP_RESET];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("reset bit did not clear");

  property p_ascend;
    @(posedge ref_clk) disable iff (!resetn)
      (clk_en && rst_state == SCRB_IDLE && rd_en && !wr_en && !addr_load && !ai.freeze)
        |=> addr == 15'($past(addr) + ($past(ai.ascend) ? 15'h0001 : 15'h7fff));
  endproperty
  a_ascend: assert property (p_ascend) else $error("address step wrong");

  property p_flag;
    @(posedge ref_clk) disable iff (!resetn) sif_cfg[SCRB_BIT_SEP_OUTPUT] && sdo_select;
  endproperty
  a_flag: assert property (p_flag) else $error("separate-output flag not one");

  property p_pdown;
    @(posedge ref_clk) disable iff (!resetn)
      clk_en |=> power_down == (chip_operating_mode[1:0] == SCRB_MODE_PDOWN);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down not tied to mode");

  property p_maker;
    @(posedge ref_clk) disable iff (!resetn)
      (clk_en && rst_state == SCRB_IDLE && rd_en && !addr_load && addr == SCRB_OFS_MAKER_LO)
        |=> rd_data == SCRB_MAKER_CODE[7:0];
  endproperty
  a_maker: assert property (p_maker) else $error("maker code read wrong");

  property p_freeze;
    @(posedge ref_clk) disable iff (!resetn)
      (clk_en && rst_state == SCRB_IDLE && rd_en && !addr_load && !wr_en && ai.freeze) |=> $stable(addr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen address moved");

  property p_tref;
    @(posedge ref_clk) disable iff (!resetn)
      clk_en |=> align_delay_choice == timing_reference_control[3:0]
                 && align_receiver_enable == timing_reference_control[SCRB_BIT_ALIGN_RECV];
  endproperty
  a_tref: assert property (p_tref) else $error("alignment outputs mismatch");

  property p_quiet;
    @(posedge ref_clk) disable iff (!resetn)
      s_reset_write ##1 clk_en[*1] |-> chip_reset_busy;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet period not signalled");

endmodule : scrb_bank

// >>> hw/scrb_pkg.sv
/*
  Package for the serial-port configuration register bank: offsets, reset values,
  field positions, mode codes and reset timing.
  Assumes a 200 MHz ref_clk and an external serial frame engine.
*/
package scrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (register address space is 15 bits)
  localparam logic [14:0] SCRB_OFS_SIF_CFG    = 15'h0000;
  localparam logic [14:0] SCRB_OFS_OP_MODE    = 15'h0002;
  localparam logic [14:0] SCRB_OFS_MAKER_LO   = 15'h000c;
  localparam logic [14:0] SCRB_OFS_MAKER_HI   = 15'h000d;
  localparam logic [14:0] SCRB_OFS_STREAM_CTL = 15'h0010;
  localparam logic [14:0] SCRB_OFS_TREF_CTL   = 15'h0029;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  SCRB_RST_SIF_CFG    = 8'h30;
  localparam logic [7:0]  SCRB_RST_OP_MODE    = 8'h00;
  localparam logic [7:0]  SCRB_RST_STREAM_CTL = 8'h00;
  localparam logic [7:0]  SCRB_RST_TREF_CTL   = 8'h80;
  localparam logic [15:0] SCRB_MAKER_CODE     = 16'h5a3c; // Arbitrary value

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SCRB_BIT_CHIP_RESET   = 7;
  localparam int SCRB_BIT_ASCEND       = 5;
  localparam int SCRB_BIT_SEP_OUTPUT   = 4;
  localparam int SCRB_BIT_ADDR_FREEZE  = 0;
  localparam int SCRB_BIT_ALIGN_PROC   = 6;
  localparam int SCRB_BIT_ALIGN_RECV   = 5;
  localparam int SCRB_BIT_ALIGN_FINE   = 4;

  // Operating mode codes
  localparam logic [1:0] SCRB_MODE_NORMAL = 2'h0;
  localparam logic [1:0] SCRB_MODE_PDOWN  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Chip reset quiet period
  localparam int SCRB_QUIET_NS     = 750;
  localparam int SCRB_CLK_PERIOD_PS = 5000;
  localparam int SCRB_QUIET_CYC    = (SCRB_QUIET_NS * 1000) / SCRB_CLK_PERIOD_PS;
  localparam logic [7:0] SCRB_QUIET_CYC_W = 8'(SCRB_QUIET_CYC);

  typedef enum logic [1:0] {
    SCRB_IDLE,
    SCRB_RESETTING
  } scrb_rst_state_t;

endpackage : scrb_pkg

// >>> hw/scrb_addr_if.sv
/*
  Interface carrying address stepping request and answer between the bank and
  its address stepper.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface scrb_addr_if;
  logic [14:0] cur_addr;
  logic        ascend;
  logic        freeze;
  logic [14:0] next_addr;

  modport bank    (output cur_addr, output ascend, output freeze, input next_addr);
  modport stepper (input cur_addr, input ascend, input freeze, output next_addr);
endinterface : scrb_addr_if

// >>> hw/scrb_addr_step.sv
/*
  Streaming address stepper: holds, increments or decrements the address.
  Assumes it is driven from the bank through scrb_addr_if.
*/
`timescale 1ns/1ps
module scrb_addr_step
  import scrb_pkg::*;
(
  scrb_addr_if.stepper a
);

  // Freeze wins, otherwise direction chooses the step
  always_comb begin
    if (a.freeze) begin
      a.next_addr = a.cur_addr;
    end else if (a.ascend) begin
      a.next_addr = 15'(a.cur_addr + 15'h0001);
    end else begin
      a.next_addr = 15'(a.cur_addr - 15'h0001);
    end
  end

endmodule : scrb_addr_step

// >>> verif/scrb_host.sv
/*
  Host model for the register bank: starts streams, writes and reads bytes.
  Assumes ref_clk comes from the bench; all strobes change on falling edges.
*/
`timescale 1ns/1ps
module scrb_host (
  input  wire logic        ref_clk,
  input  wire logic        chip_reset_busy,
  input  wire logic [7:0]  rd_data,
  output logic             clk_en,
  output logic             addr_load,
  output logic [14:0]      addr_in,
  output logic             wr_en,
  output logic [7:0]       wr_data,
  output logic             rd_en
);
  // Idle strobes from time zero
  initial begin
    clk_en    = 1'b1;
    addr_load = 1'b0;
    addr_in   = 15'h0000;
    wr_en     = 1'b0;
    wr_data   = 8'h00;
    rd_en     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start a stream; the released address shows its inverse
  task automatic load(input logic [14:0] a);
    @(negedge ref_clk);
    addr_load <= 1'b1;
    addr_in   <= a;
    @(negedge ref_clk);
    addr_load <= 1'b0;
    addr_in   <= ~a;
  endtask : load

  // One byte; callers keep reserved bits at reset values and order the enables
  task automatic write(input logic [7:0] d, input logic en);
    @(negedge ref_clk);
    clk_en  <= en;
    wr_en   <= 1'b1;
    wr_data <= d;
    @(negedge ref_clk);
    clk_en  <= 1'b1;
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask : write

  // Back-to-back reads taken from the dedicated output line
  task automatic read(input int n, output logic [7:0] q[$]);
    q = {};
    @(negedge ref_clk);
    rd_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      if (i == n - 1) rd_en <= 1'b0;
      q.push_back(rd_data);
    end
  endtask : read

  // Stay silent after a chip reset until the quiet period is over
  task automatic quiet(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 1000 && !ok; i++) begin
      @(negedge ref_clk);
      ok = (chip_reset_busy === 1'b0);
    end
  endtask : quiet
endmodule : scrb_host

// >>> verif/tb.sv
/*
  Self-checking bench for the register bank against an integer register model.
  Assumes scrb_host drives every access and ref_clk runs at 200 MHz.
*/
`timescale 1ns/1ps
module tb;
  import scrb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        clk_en, addr_load, wr_en, rd_en;
  logic [14:0] addr_in;
  logic [7:0]  wr_data, rd_data;
  logic        sdo_select, chip_reset_busy, power_down;
  logic [1:0]  op_mode;
  logic        align_processor_enable, align_receiver_enable, align_fine_window_step;
  logic [3:0]  align_delay_choice;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          seed = 32'h4b164f36;
  int          busy_cycles = 0;
  int          m_reg[int];
  int          m_addr;
  logic [7:0]  q[$];
  bit          ok;

  // Clock and quiet-period counter
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (chip_reset_busy === 1'b1) busy_cycles++;

  scrb_host host (.ref_clk, .chip_reset_busy, .rd_data, .clk_en, .addr_load, .addr_in, .wr_en, .wr_data, .rd_en);
  scrb_bank DUT (.ref_clk, .resetn, .clk_en, .addr_load, .addr_in, .wr_en, .wr_data, .rd_en, .rd_data,
                 .sdo_select, .chip_reset_busy, .power_down, .op_mode, .align_processor_enable,
                 .align_receiver_enable, .align_fine_window_step, .align_delay_choice);

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Reference model: reset values, reads, writes and address stepping
  function automatic void m_reset();
    m_reg[SCRB_OFS_SIF_CFG]    = SCRB_RST_SIF_CFG;
    m_reg[SCRB_OFS_OP_MODE]    = SCRB_RST_OP_MODE;
    m_reg[SCRB_OFS_MAKER_LO]   = SCRB_MAKER_CODE[7:0];
    m_reg[SCRB_OFS_MAKER_HI]   = SCRB_MAKER_CODE[15:8];
    m_reg[SCRB_OFS_STREAM_CTL] = SCRB_RST_STREAM_CTL;
    m_reg[SCRB_OFS_TREF_CTL]   = SCRB_RST_TREF_CTL;
  endfunction : m_reset

  function automatic int m_rd(int a);
    return m_reg.exists(a) ? m_reg[a] : 0;
  endfunction : m_rd

  function automatic void m_wr(int a, int d);
    if (a == SCRB_OFS_SIF_CFG && d[7]) m_reset();
    else if (a == SCRB_OFS_SIF_CFG) m_reg[a] = (d & 'h6f) | 'h10;
    else if (m_reg.exists(a) && a != SCRB_OFS_MAKER_LO && a != SCRB_OFS_MAKER_HI) m_reg[a] = d & 'hff;
  endfunction : m_wr

  function automatic void m_step();
    if (m_reg[SCRB_OFS_STREAM_CTL] % 2 == 0)
      m_addr = (m_addr + ((m_reg[SCRB_OFS_SIF_CFG] & 'h20) ? 1 : -1)) & 'h7fff;
  endfunction : m_step

  ////////////////////////////////////////////////////////////////////////////
  // Write one byte at an address, in the bank and in the model
  task automatic put(input int a, input int d);
    host.load(15'(a));
    host.write(8'(d), 1'b1);
    m_wr(a, d);
  endtask : put

  // Stream-read n bytes from an address and compare each
  task automatic get(input int a, input int n);
    host.load(15'(a));
    host.read(n, q);
    m_addr = a;
    foreach (q[i]) begin
      chk("rd_data", 16'(m_rd(m_addr)), {8'h00, q[i]});
      m_step();
    end
  endtask : get

  // Compare every control output with the model
  task automatic outs();
    logic [15:0] al;
    al = {9'h0, align_processor_enable, align_receiver_enable, align_fine_window_step, align_delay_choice};
    chk("op_mode", 16'(m_reg[SCRB_OFS_OP_MODE] & 3), {14'h0, op_mode});
    chk("power_down", 16'((m_reg[SCRB_OFS_OP_MODE] & 3) == 3), {15'h0, power_down});
    chk("align", 16'(m_reg[SCRB_OFS_TREF_CTL] & 'h7f), al);
    chk("sdo_select", 16'h0001, {15'h0, sdo_select});
  endtask : outs

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    m_reset();
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    // Reset values, maker code bytes and unmapped places
    get(SCRB_OFS_SIF_CFG, 3);
    get(SCRB_OFS_MAKER_LO - 1, 5);
    get(SCRB_OFS_STREAM_CTL, 1);
    get(SCRB_OFS_TREF_CTL, 1);
    outs();
    // Read-only places ignore writes
    put(SCRB_OFS_MAKER_LO, $random(seed));
    put(SCRB_OFS_MAKER_HI, $random(seed));
    put(SCRB_OFS_SIF_CFG, 'h20);
    get(SCRB_OFS_SIF_CFG, 1);
    get(SCRB_OFS_MAKER_LO, 2);
    // Every mode code
    for (int m = 0; m < 4; m++) begin
      put(SCRB_OFS_OP_MODE, m);
      outs();
    end
    // Descending stream, then a frozen address
    put(SCRB_OFS_SIF_CFG, 'h00);
    get(SCRB_OFS_MAKER_HI, 3);
    put(SCRB_OFS_SIF_CFG, 'h20);
    put(SCRB_OFS_STREAM_CTL, 'h01);
    get(SCRB_OFS_MAKER_LO, 3);
    put(SCRB_OFS_STREAM_CTL, 'h00);
    // Alignment enables, receiver first, random fine step and delay
    put(SCRB_OFS_TREF_CTL, 'ha0);
    outs();
    put(SCRB_OFS_TREF_CTL, 'he0 | ($random(seed) & 'h1f));
    outs();
    get(SCRB_OFS_TREF_CTL, 1);
    // Gated clock keeps the mode
    host.load(SCRB_OFS_OP_MODE);
    host.write(8'h00, 1'b0);
    outs();
    // Chip reset with a refused write during the quiet period
    busy_cycles = 0;
    put(SCRB_OFS_SIF_CFG, 'h80);
    host.load(SCRB_OFS_OP_MODE);
    host.write(8'h02, 1'b1);
    host.quiet(ok);
    if (!ok) begin
      bad_count++;
      $display("wrong value chip_reset_busy expected %h seen %h", 1'b0, chip_reset_busy);
    end
    if (ok) begin
      chk("quiet cycles", 16'(SCRB_QUIET_CYC), 16'(busy_cycles));
      get(SCRB_OFS_SIF_CFG, 3);
      get(SCRB_OFS_STREAM_CTL, 1);
      get(SCRB_OFS_TREF_CTL, 1);
      outs();
    end
    give_verdict();
  end
endmodule : tb
